// ### rtl/asp_dev.sv
// Device end of the serial port: Avalon-MM register slave, transmitter and receiver
// What this block does
// - Mode bit selects 8-bit or 9-bit framing
// - 8-bit frame: start, eight data LSB first, stop
// - Data buffer write loads and starts transmission
// - Transmit flag set at stop bit start
// - Receiver accepts characters only while enabled
// - 8-bit load: flag clear, stop checked if enabled
// - Failed conditions leave buffer, ninth, flag unchanged
// - Overrun keeps first byte, drops later ones
// - 9-bit frame adds programmable ninth bit
// - Ninth transmit field used only in 9-bit
// - 9-bit load: stop ignored, ninth filtered
// - Interrupt when enabled and either flag set
// - Receive flag set at stop sampling
// - Hardware only sets flags; software clears
// - Control bit 6 reads one, ignores writes
// - Master sends addresses ninth=1, data ninth=0
// - Slave software toggles filter around messages
// - Bit ticks are timer overflows divided by two
// - Receive timer reloads on start detection
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "asp_regs.svh"
module asp_dev (
   input wire logic ref_clk, // 20 MHz clock
   input wire logic resetn, // Asynchronous reset
   input wire logic [9:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   output logic irq, // Interrupt request
   asp_ser_if.dev ser // Serial lines
);

   // ----------------------------------------
   // Register slave
   // ----------------------------------------
   logic [7:0] ctrl_reg, ctrl_next;
   logic ien_reg, ien_next;
   logic [7:0] rld_reg, rld_next;
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic [7:0] idx;
   logic tx_go;
   logic ti_set;
   logic rx_load;
   logic rx_rb8;
   logic [7:0] rx_buf_reg, rx_buf_next;

   always_comb begin
      idx = avs_address[9:2];
      ctrl_next = ctrl_reg;
      ien_next = ien_reg;
      rld_next = rld_reg;
      rdata_next = rdata_reg;
      tx_go = 1'b0;
      // One wait state: the answer stands at the second edge of each request
      wait_next = !((avs_read || avs_write) && wait_reg);
      if (avs_read && wait_reg) begin
         unique case (idx)
            `ASP_IDX_CTRL: rdata_next = {24'h000000, ctrl_reg | `ASP_CTRL_FIXED};
            `ASP_IDX_DATA: rdata_next = {24'h000000, rx_buf_reg};
            `ASP_IDX_IEN: rdata_next = {31'h00000000, ien_reg};
            `ASP_IDX_RELOAD: rdata_next = {24'h000000, rld_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
      if (avs_write && !wait_reg && avs_byteenable[0]) begin
         unique case (idx)
            `ASP_IDX_CTRL: ctrl_next = avs_writedata[7:0] | `ASP_CTRL_FIXED;
            `ASP_IDX_DATA: tx_go = 1'b1;
            `ASP_IDX_IEN: ien_next = avs_writedata[0];
            `ASP_IDX_RELOAD: rld_next = avs_writedata[7:0];
            default: ;
         endcase
      end
      // Hardware sets after the software write so that a set in the clearing cycle wins
      if (rx_load) begin
         ctrl_next[`ASP_B_RB8] = rx_rb8;
         ctrl_next[`ASP_B_RI] = 1'b1;
      end
      if (ti_set) begin
         ctrl_next[`ASP_B_TI] = 1'b1;
      end
      irq_next = ien_reg && (ctrl_reg[`ASP_B_TI] || ctrl_reg[`ASP_B_RI]);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= `ASP_CTRL_RESET;
         ien_reg <= 1'b0;
         rld_reg <= `ASP_RELOAD_RESET;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         ien_reg <= ien_next;
         rld_reg <= rld_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;
   assign irq = irq_reg;

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   asp_pkg::asp_state_t tst_reg, tst_next;
   logic [7:0] ttmr_reg, ttmr_next;
   logic thalf_reg, thalf_next;
   logic [2:0] tcnt_reg, tcnt_next;
   logic [7:0] tsh_reg, tsh_next;
   logic tnin_reg, tnin_next;
   logic tline_reg, tline_next;
   logic ttick;

   always_comb begin
      ttmr_next = (ttmr_reg == `ASP_TMR_TOP) ? rld_reg : ttmr_reg + 8'h01;
      thalf_next = (ttmr_reg == `ASP_TMR_TOP) ? !thalf_reg : thalf_reg;
      ttick = (ttmr_reg == `ASP_TMR_TOP) && thalf_reg;
      tst_next = tst_reg;
      tcnt_next = tcnt_reg;
      tsh_next = tsh_reg;
      tnin_next = tnin_reg;
      tline_next = tline_reg;
      ti_set = 1'b0;
      if (tx_go) begin
         // A write during a frame restarts it with the new byte
         tst_next = asp_pkg::ASP_START;
         tsh_next = avs_writedata[7:0];
         tnin_next = ctrl_reg[`ASP_B_TB8];
         tline_next = 1'b1;
      end else if (ttick) begin
         unique case (tst_reg)
            asp_pkg::ASP_IDLE: ;
            asp_pkg::ASP_START: begin
               tline_next = 1'b0;
               tcnt_next = 3'h0;
               tst_next = asp_pkg::ASP_DATA;
            end
            asp_pkg::ASP_DATA: begin
               tline_next = tsh_reg[0];
               tsh_next = {1'b0, tsh_reg[7:1]};
               tcnt_next = tcnt_reg + 3'h1;
               if (tcnt_reg == `ASP_LAST_BIT) begin
                  tst_next = ctrl_reg[`ASP_B_MODE] ? asp_pkg::ASP_NINTH : asp_pkg::ASP_STOP;
               end
            end
            asp_pkg::ASP_NINTH: begin
               tline_next = tnin_reg;
               tst_next = asp_pkg::ASP_STOP;
            end
            asp_pkg::ASP_STOP: begin
               tline_next = 1'b1;
               ti_set = 1'b1;
               tst_next = asp_pkg::ASP_FIN;
            end
            asp_pkg::ASP_FIN: tst_next = asp_pkg::ASP_IDLE;
            default: tst_next = asp_pkg::ASP_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tst_reg <= asp_pkg::ASP_IDLE;
         ttmr_reg <= 8'h00;
         thalf_reg <= 1'b0;
         tcnt_reg <= 3'h0;
         tsh_reg <= 8'h00;
         tnin_reg <= 1'b0;
         tline_reg <= 1'b1;
      end else begin
         tst_reg <= tst_next;
         ttmr_reg <= ttmr_next;
         thalf_reg <= thalf_next;
         tcnt_reg <= tcnt_next;
         tsh_reg <= tsh_next;
         tnin_reg <= tnin_next;
         tline_reg <= tline_next;
      end
   end

   assign ser.serial_tx_line = tline_reg;

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   asp_pkg::asp_state_t rst_reg, rst_next;
   logic s1_reg, s2_reg, s3_reg;
   logic rlvl_reg, rlvl_next;
   logic rprev_reg;
   logic [7:0] rtmr_reg, rtmr_next;
   logic rhalf_reg, rhalf_next;
   logic [2:0] rcnt_reg, rcnt_next;
   logic [7:0] rsh_reg, rsh_next;
   logic rnin_reg, rnin_next;
   logic rsamp;
   logic rok;

   always_comb begin
      // Level changes only once the second and third stages agree
      rlvl_next = (s2_reg == s3_reg) ? s3_reg : rlvl_reg;
      rtmr_next = (rtmr_reg == `ASP_TMR_TOP) ? rld_reg : rtmr_reg + 8'h01;
      rhalf_next = (rtmr_reg == `ASP_TMR_TOP) ? !rhalf_reg : rhalf_reg;
      // First overflow after the start edge is half a bit in, then every bit
      rsamp = (rtmr_reg == `ASP_TMR_TOP) && !rhalf_reg;
      rst_next = rst_reg;
      rcnt_next = rcnt_reg;
      rsh_next = rsh_reg;
      rnin_next = rnin_reg;
      rx_buf_next = rx_buf_reg;
      rx_load = 1'b0;
      rx_rb8 = 1'b0;
      rok = 1'b0;
      if (!ctrl_reg[`ASP_B_REN]) begin
         rst_next = asp_pkg::ASP_IDLE;
      end else if (rst_reg == asp_pkg::ASP_IDLE) begin
         if (rprev_reg && !rlvl_reg) begin
            rtmr_next = rld_reg;
            rhalf_next = 1'b0;
            rst_next = asp_pkg::ASP_START;
         end
      end else if (rsamp) begin
         unique case (rst_reg)
            asp_pkg::ASP_START: begin
               rcnt_next = 3'h0;
               rst_next = rlvl_reg ? asp_pkg::ASP_IDLE : asp_pkg::ASP_DATA;
            end
            asp_pkg::ASP_DATA: begin
               rsh_next = {rlvl_reg, rsh_reg[7:1]};
               rcnt_next = rcnt_reg + 3'h1;
               if (rcnt_reg == `ASP_LAST_BIT) begin
                  rst_next = ctrl_reg[`ASP_B_MODE] ? asp_pkg::ASP_NINTH : asp_pkg::ASP_STOP;
               end
            end
            asp_pkg::ASP_NINTH: begin
               rnin_next = rlvl_reg;
               rst_next = asp_pkg::ASP_STOP;
            end
            asp_pkg::ASP_STOP: begin
               if (ctrl_reg[`ASP_B_MODE]) begin
                  rx_rb8 = rnin_reg;
                  rok = !ctrl_reg[`ASP_B_RI] && (!ctrl_reg[`ASP_B_MCE] || rnin_reg);
               end else begin
                  rx_rb8 = rlvl_reg;
                  rok = !ctrl_reg[`ASP_B_RI] && (!ctrl_reg[`ASP_B_MCE] || rlvl_reg);
               end
               // With the flag still set the buffer keeps the first byte
               if (rok) begin
                  rx_buf_next = rsh_reg;
                  rx_load = 1'b1;
               end
               rst_next = asp_pkg::ASP_IDLE;
            end
            default: rst_next = asp_pkg::ASP_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_reg <= asp_pkg::ASP_IDLE;
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         rlvl_reg <= 1'b1;
         rprev_reg <= 1'b1;
         rtmr_reg <= 8'h00;
         rhalf_reg <= 1'b0;
         rcnt_reg <= 3'h0;
         rsh_reg <= 8'h00;
         rnin_reg <= 1'b0;
         rx_buf_reg <= 8'h00;
      end else begin
         rst_reg <= rst_next;
         s1_reg <= ser.serial_rx_line;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         rlvl_reg <= rlvl_next;
         rprev_reg <= rlvl_reg;
         rtmr_reg <= rtmr_next;
         rhalf_reg <= rhalf_next;
         rcnt_reg <= rcnt_next;
         rsh_reg <= rsh_next;
         rnin_reg <= rnin_next;
         rx_buf_reg <= rx_buf_next;
      end
   end

endmodule

// ### rtl/asp_far.sv
// Remote end of the serial port: plain send and receive ports on the same framing
`timescale 1ns/100ps
`include "asp_regs.svh"
module asp_far (
   input wire logic ref_clk, // 20 MHz clock
   input wire logic resetn, // Asynchronous reset
   input wire logic [7:0] reload, // Timer reload value
   input wire logic nine_bit_mode, // 1 selects 11-bit frames
   input wire logic send_req, // Start a frame, one cycle
   input wire logic [7:0] send_data, // Byte to send
   input wire logic send_ninth, // Ninth bit: 1 address, 0 data
   output logic send_busy, // Frame in progress
   output logic recv_valid, // Character received, one cycle
   output logic [7:0] recv_data, // Received byte
   output logic recv_ninth, // Received ninth or stop bit
   asp_ser_if.far ser // Serial lines
);

   // ----------------------------------------
   // Bit timing
   // ----------------------------------------
   logic [7:0] tmr_reg, tmr_next;
   logic half_reg, half_next;
   logic [7:0] rtmr_reg, rtmr_next;
   logic rhalf_reg, rhalf_next;
   logic tick;
   logic rsamp;

   // ----------------------------------------
   // Sender and receiver
   // ----------------------------------------
   asp_pkg::asp_state_t tst_reg, tst_next, rst_reg, rst_next;
   logic [2:0] tcnt_reg, tcnt_next, rcnt_reg, rcnt_next;
   logic [7:0] tsh_reg, tsh_next, rsh_reg, rsh_next;
   logic tnin_reg, tnin_next, line_reg, line_next, busy_reg, busy_next;
   logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next, prev_reg;
   logic val_reg, val_next, rnin_reg, rnin_next;
   logic [7:0] rdat_reg, rdat_next;

   always_comb begin
      tmr_next = (tmr_reg == `ASP_TMR_TOP) ? reload : tmr_reg + 8'h01;
      half_next = (tmr_reg == `ASP_TMR_TOP) ? !half_reg : half_reg;
      tick = (tmr_reg == `ASP_TMR_TOP) && half_reg;
      tst_next = tst_reg;
      tcnt_next = tcnt_reg;
      tsh_next = tsh_reg;
      tnin_next = tnin_reg;
      line_next = line_reg;
      // Requests while busy are ignored; the user waits for busy to fall
      if (send_req && !busy_reg) begin
         tst_next = asp_pkg::ASP_START;
         tsh_next = send_data;
         tnin_next = send_ninth;
      end else if (tick) begin
         unique case (tst_reg)
            asp_pkg::ASP_IDLE: ;
            asp_pkg::ASP_START: begin
               line_next = 1'b0;
               tcnt_next = 3'h0;
               tst_next = asp_pkg::ASP_DATA;
            end
            asp_pkg::ASP_DATA: begin
               line_next = tsh_reg[0];
               tsh_next = {1'b0, tsh_reg[7:1]};
               tcnt_next = tcnt_reg + 3'h1;
               if (tcnt_reg == `ASP_LAST_BIT) begin
                  tst_next = nine_bit_mode ? asp_pkg::ASP_NINTH : asp_pkg::ASP_STOP;
               end
            end
            asp_pkg::ASP_NINTH: begin
               line_next = tnin_reg;
               tst_next = asp_pkg::ASP_STOP;
            end
            asp_pkg::ASP_STOP: begin
               line_next = 1'b1;
               tst_next = asp_pkg::ASP_FIN;
            end
            asp_pkg::ASP_FIN: tst_next = asp_pkg::ASP_IDLE;
            default: tst_next = asp_pkg::ASP_IDLE;
         endcase
      end
      busy_next = (tst_next != asp_pkg::ASP_IDLE);
   end

   always_comb begin
      lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
      rtmr_next = (rtmr_reg == `ASP_TMR_TOP) ? reload : rtmr_reg + 8'h01;
      rhalf_next = (rtmr_reg == `ASP_TMR_TOP) ? !rhalf_reg : rhalf_reg;
      rsamp = (rtmr_reg == `ASP_TMR_TOP) && !rhalf_reg;
      rst_next = rst_reg;
      rcnt_next = rcnt_reg;
      rsh_next = rsh_reg;
      rnin_next = rnin_reg;
      rdat_next = rdat_reg;
      val_next = 1'b0;
      if (rst_reg == asp_pkg::ASP_IDLE) begin
         if (prev_reg && !lvl_reg) begin
            rtmr_next = reload;
            rhalf_next = 1'b0;
            rst_next = asp_pkg::ASP_START;
         end
      end else if (rsamp) begin
         unique case (rst_reg)
            asp_pkg::ASP_START: begin
               rcnt_next = 3'h0;
               rst_next = lvl_reg ? asp_pkg::ASP_IDLE : asp_pkg::ASP_DATA;
            end
            asp_pkg::ASP_DATA: begin
               rsh_next = {lvl_reg, rsh_reg[7:1]};
               rcnt_next = rcnt_reg + 3'h1;
               if (rcnt_reg == `ASP_LAST_BIT) begin
                  rst_next = nine_bit_mode ? asp_pkg::ASP_NINTH : asp_pkg::ASP_STOP;
               end
            end
            asp_pkg::ASP_NINTH: begin
               rnin_next = lvl_reg;
               rst_next = asp_pkg::ASP_STOP;
            end
            asp_pkg::ASP_STOP: begin
               rdat_next = rsh_reg;
               rnin_next = nine_bit_mode ? rnin_reg : lvl_reg;
               val_next = 1'b1;
               rst_next = asp_pkg::ASP_IDLE;
            end
            default: rst_next = asp_pkg::ASP_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tmr_reg <= 8'h00;
         half_reg <= 1'b0;
         rtmr_reg <= 8'h00;
         rhalf_reg <= 1'b0;
         tst_reg <= asp_pkg::ASP_IDLE;
         rst_reg <= asp_pkg::ASP_IDLE;
         tcnt_reg <= 3'h0;
         rcnt_reg <= 3'h0;
         tsh_reg <= 8'h00;
         rsh_reg <= 8'h00;
         tnin_reg <= 1'b0;
         line_reg <= 1'b1;
         busy_reg <= 1'b0;
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         lvl_reg <= 1'b1;
         prev_reg <= 1'b1;
         val_reg <= 1'b0;
         rnin_reg <= 1'b0;
         rdat_reg <= 8'h00;
      end else begin
         tmr_reg <= tmr_next;
         half_reg <= half_next;
         rtmr_reg <= rtmr_next;
         rhalf_reg <= rhalf_next;
         tst_reg <= tst_next;
         rst_reg <= rst_next;
         tcnt_reg <= tcnt_next;
         rcnt_reg <= rcnt_next;
         tsh_reg <= tsh_next;
         rsh_reg <= rsh_next;
         tnin_reg <= tnin_next;
         line_reg <= line_next;
         busy_reg <= busy_next;
         s1_reg <= ser.serial_tx_line;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
         prev_reg <= lvl_reg;
         val_reg <= val_next;
         rnin_reg <= rnin_next;
         rdat_reg <= rdat_next;
      end
   end

   assign ser.serial_rx_line = line_reg;
   assign send_busy = busy_reg;
   assign recv_valid = val_reg;
   assign recv_data = rdat_reg;
   assign recv_ninth = rnin_reg;

endmodule

// ### rtl/asp_pkg.sv
// Shared types of the serial port ends
package asp_pkg;
   typedef enum logic [2:0] {
      ASP_IDLE  = 3'h0,
      ASP_START = 3'h1,
      ASP_DATA  = 3'h2,
      ASP_NINTH = 3'h3,
      ASP_STOP  = 3'h4,
      ASP_FIN   = 3'h5
   } asp_state_t;
endpackage

// ### rtl/asp_regs.svh
// Register indices, field positions, reset values and timing constants of the serial port
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

// Register indices; the byte address is four times the index
`define ASP_IDX_CTRL 8'h98
`define ASP_IDX_DATA 8'h99
`define ASP_IDX_IEN 8'h9A
`define ASP_IDX_RELOAD 8'h9B

// Control register fields
`define ASP_B_MODE 7
`define ASP_B_FIXED 6
`define ASP_B_MCE 5
`define ASP_B_REN 4
`define ASP_B_TB8 3
`define ASP_B_RB8 2
`define ASP_B_TI 1
`define ASP_B_RI 0

// Reset values
`define ASP_CTRL_RESET 8'h40
`define ASP_CTRL_FIXED 8'h40
`define ASP_RELOAD_RESET 8'hF0

// Timer overflow value and last data bit index
`define ASP_TMR_TOP 8'hFF
`define ASP_LAST_BIT 3'h7

`endif

// ### rtl/asp_ser_if.sv
// Serial line pair between the device end and the remote end
`timescale 1ns/100ps
interface asp_ser_if;
   logic serial_tx_line; // Device to remote
   logic serial_rx_line; // Remote to device
   modport dev (output serial_tx_line, input serial_rx_line);
   modport far (output serial_rx_line, input serial_tx_line);
endinterface

// ### test/asp_link_asserts.sv
// Checker of the serial line pair and the remote end's frame handshake
`timescale 1ns/100ps
module asp_link_asserts (
   input wire logic ref_clk, // Clock
   input wire logic resetn, // Reset
   input wire logic serial_tx_line, // Device to remote
   input wire logic serial_rx_line, // Remote to device
   input wire logic send_req, // Remote frame request
   input wire logic send_busy, // Remote frame in progress
   input wire logic recv_valid // Remote character strobe
);
   // ----------------------------------------
   // Frame length counter
   // ----------------------------------------
   logic [7:0] busy_cnt_reg;
   logic [7:0] busy_cnt_next;
   always_comb begin
      busy_cnt_next = send_busy ? busy_cnt_reg + 8'h01 : 8'h00;
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_cnt_reg <= 8'h00;
      end else begin
         busy_cnt_reg <= busy_cnt_next;
      end
   end
   // ----------------------------------------
   // Properties, 8 clocks per bit at reload FC
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_start_seen;
      send_busy ##[0:10] !serial_rx_line;
   endsequence
   chk_rx_low_bit: assert property ($fell(serial_rx_line) |-> !serial_rx_line [*8])
      else $error("Remote line low under one bit");
   chk_rx_high_bit: assert property ($rose(serial_rx_line) |-> serial_rx_line [*8])
      else $error("Remote line high under one bit");
   chk_tx_low_bit: assert property ($fell(serial_tx_line) |-> !serial_tx_line [*8])
      else $error("Device line low under one bit");
   chk_tx_high_bit: assert property ($rose(serial_tx_line) |-> serial_tx_line [*8])
      else $error("Device line high under one bit");
   chk_send_start: assert property (send_req && !send_busy |=> s_start_seen)
      else $error("No start bit after send");
   chk_frame_length: assert property ($fell(send_busy) |-> busy_cnt_reg inside {[8'h50:8'h68]})
      else $error("Frame length wrong");
   chk_busy_idle: assert property ($fell(send_busy) |-> serial_rx_line)
      else $error("Line not idle after frame");
   chk_valid_pulse: assert property (recv_valid |=> !recv_valid)
      else $error("Receive strobe too long");
endmodule

// ### test/test_async_serial_port_modes.sv
// Self-checking bench joining the device end and the remote end
`timescale 1ns/100ps
`include "asp_regs.svh"
module test_async_serial_port_modes;
   localparam logic [7:0] ctrl_idx = `ASP_IDX_CTRL;
   localparam logic [7:0] data_idx = `ASP_IDX_DATA;
   localparam logic [7:0] ien_idx = `ASP_IDX_IEN;
   localparam logic [7:0] rld_idx = `ASP_IDX_RELOAD;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic nine_bit_mode = 1'b0;
   logic send_req = 1'b0;
   logic [7:0] send_data = 8'h00;
   logic send_ninth = 1'b0;
   logic send_busy;
   logic recv_valid;
   logic [7:0] recv_data;
   logic recv_ninth;
   logic [7:0] rd;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   asp_ser_if u_asp_ser_if();
   asp_dev u_asp_dev(.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .ser(u_asp_ser_if.dev));
   asp_far u_asp_far(.ref_clk(ref_clk), .resetn(resetn), .reload(8'hFC), .nine_bit_mode(nine_bit_mode),
      .send_req(send_req), .send_data(send_data), .send_ninth(send_ninth), .send_busy(send_busy),
      .recv_valid(recv_valid), .recv_data(recv_data), .recv_ninth(recv_ninth), .ser(u_asp_ser_if.far));
   asp_link_asserts u_asp_link_asserts(.ref_clk(ref_clk), .resetn(resetn),
      .serial_tx_line(u_asp_ser_if.serial_tx_line), .serial_rx_line(u_asp_ser_if.serial_rx_line),
      .send_req(send_req), .send_busy(send_busy), .recv_valid(recv_valid));
   // ----------------------------------------
   // Clock, watchdog and shared tasks
   // ----------------------------------------
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // About ten frames of 100 clocks are expected
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic av_write(input logic [7:0] idx, input logic [7:0] data);
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, data};
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      chk(name, exp, rd);
      // Unused read lanes must stay zero
      chk({name, " upper"}, 8'h00, avs_readdata[31:24] | avs_readdata[23:16] | avs_readdata[15:8]);
   endtask
   task automatic dev_send(input logic [7:0] d, input logic n);
      av_write(data_idx, d);
      do @(posedge ref_clk); while (recv_valid !== 1'b1);
      chk("remote byte", d, recv_data);
      chk("remote ninth", {7'h00, n}, {7'h00, recv_ninth});
   endtask
   // Receiver loads at stop centre, a cycle or two after the sender drops busy
   task automatic far_send(input logic [7:0] d, input logic n);
      @(posedge ref_clk);
      send_data <= d;
      send_ninth <= n;
      send_req <= 1'b1;
      @(posedge ref_clk);
      send_req <= 1'b0;
      do @(posedge ref_clk); while (send_busy !== 1'b0);
      repeat (8) @(posedge ref_clk);
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      rd_chk("control reset", ctrl_idx, 8'h40);
      rd_chk("reload reset", rld_idx, 8'hF0);
      av_write(ctrl_idx, 8'h00);
      rd_chk("control bit 6", ctrl_idx, 8'h40);
      rd_chk("unmapped", 8'h10, 8'h00);
      av_write(rld_idx, 8'hFC);
      av_write(ien_idx, 8'h01);
      $display("Test registers done");
      dev_send(8'hA5, 1'b1);
      chk("irq tx", 8'h01, {7'h00, irq});
      rd_chk("tx flag", ctrl_idx, 8'h42);
      av_write(ctrl_idx, 8'h88);
      nine_bit_mode <= 1'b1;
      dev_send(8'h3C, 1'b1);
      av_write(ctrl_idx, 8'h80);
      dev_send(8'hC3, 1'b0);
      $display("Test transmit done");
      av_write(ctrl_idx, 8'h30);
      nine_bit_mode <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("irq clear", 8'h00, {7'h00, irq});
      far_send(8'h96, 1'b0);
      rd_chk("rx data", data_idx, 8'h96);
      rd_chk("rx control", ctrl_idx, 8'h75);
      chk("irq rx", 8'h01, {7'h00, irq});
      far_send(8'h11, 1'b0);
      rd_chk("overrun data", data_idx, 8'h96);
      rd_chk("overrun flag", ctrl_idx, 8'h75);
      av_write(ctrl_idx, 8'h00);
      far_send(8'h22, 1'b0);
      rd_chk("disabled flags", ctrl_idx, 8'h40);
      rd_chk("disabled data", data_idx, 8'h96);
      av_write(ctrl_idx, 8'hB0);
      nine_bit_mode <= 1'b1;
      far_send(8'h33, 1'b0);
      rd_chk("filtered", ctrl_idx, 8'hF0);
      far_send(8'h44, 1'b1);
      rd_chk("address data", data_idx, 8'h44);
      rd_chk("address ctrl", ctrl_idx, 8'hF5);
      av_write(ctrl_idx, 8'h90);
      far_send(8'h55, 1'b0);
      rd_chk("message data", data_idx, 8'h55);
      rd_chk("message ctrl", ctrl_idx, 8'hD1);
      $display("Test receive done");
      stop_test();
   end
endmodule
